// *** eivc_top.sv ***
// External request edge control, vector table select and APB registers
//
// Overview of operation
// - Bit 15 selects alternate vector table
// - Bit 14 mirrors timed disable, read only
// - Bit 2 picks falling edge for request 2
// - Bit 1 picks falling edge for request 1
// - Bit 0 picks falling edge for request 0
// - Bits 13 to 3 read zero, ignore writes
// - Detected edge sets flag until software clears
// - Alternate vector equals standard plus 0x100
`timescale 1ns/10ps
`include "eivc_consts.svh"
module eivc_top (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External request pins
  input wire logic [2:0] ext_req_pin,
  // CPU status and vector fetch
  input wire logic timed_irq_disable_in,
  input wire logic vec_req,
  input wire logic [23:0] vec_std_addr,
  output logic [23:0] vec_addr,
  output logic vec_ack,
  // Interrupt
  output logic irq
);
  // ****************************************
  // State
  // ****************************************
  logic alt_vector_table_sel_r;             // Table select
  logic timed_irq_disable_active_r;         // Hardware status copy
  eivc_pkg::eivc_src_t falling_sel_r;       // Edge polarity per pin
  eivc_pkg::eivc_src_t stat_r;              // Sticky request flags
  eivc_pkg::eivc_src_t stat_nxt;            // Next flag value
  eivc_pkg::eivc_src_t mask_r;              // Interrupt mask
  logic [31:0] prdata_r;                    // Read data holding flop
  eivc_pkg::eivc_vaddr_t vec_addr_r;        // Translated vector
  logic vec_ack_r;                          // Vector valid strobe

  eivc_edge_if eif ();

  // ****************************************
  // Address decode
  // ****************************************
  // Decoder shared by read and write paths
  function automatic eivc_pkg::eivc_regsel_e sel_of(input logic [11:0] a);
    eivc_pkg::eivc_regsel_e s;
    s = eivc_pkg::EIVC_SEL_NONE;
    if (a == `EIVC_OFF_CTRL) begin
      s = eivc_pkg::EIVC_SEL_CTRL;
    end else if (a == `EIVC_OFF_STAT) begin
      s = eivc_pkg::EIVC_SEL_STAT;
    end else if (a == `EIVC_OFF_MASK) begin
      s = eivc_pkg::EIVC_SEL_MASK;
    end
    return s;
  endfunction

  wire eivc_pkg::eivc_regsel_e sel = sel_of(paddr);
  wire access = psel & penable & ce;                // Completing edge
  wire wr = access & pwrite;                        // Write strobe
  wire wr_ctrl = wr & (sel == eivc_pkg::EIVC_SEL_CTRL);
  wire wr_stat = wr & (sel == eivc_pkg::EIVC_SEL_STAT) & pstrb[0];
  wire wr_mask = wr & (sel == eivc_pkg::EIVC_SEL_MASK) & pstrb[0];

  // Control view: bits 13..3 are hard zero, no storage behind them
  wire eivc_pkg::eivc_word_t ctrl_view = {alt_vector_table_sel_r,
    timed_irq_disable_active_r, 11'h000, falling_sel_r};

  // Read mux; unmapped addresses read zero
  wire [31:0] rd_word =
    (sel == eivc_pkg::EIVC_SEL_CTRL) ? {16'h0000, ctrl_view} :
    (sel == eivc_pkg::EIVC_SEL_STAT) ? {29'h00000000, stat_r} :
    (sel == eivc_pkg::EIVC_SEL_MASK) ? {29'h00000000, mask_r} : 32'h00000000;

  // ****************************************
  // APB answers
  // ****************************************
  // Zero wait states; a low enable stretches the access instead
  assign pready = ce;
  assign pslverr = psel & penable & (sel == eivc_pkg::EIVC_SEL_NONE);
  assign prdata = prdata_r;

  // Read data captured while selected, so it is steady in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (ce && psel && !pwrite) begin
      prdata_r <= rd_word;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // Writable fields only; byte lanes honoured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_vector_table_sel_r <= `EIVC_ALT_RST;
      falling_sel_r <= `EIVC_POL_RST;
    end else if (wr_ctrl) begin
      if (pstrb[1]) begin
        alt_vector_table_sel_r <= pwdata[`EIVC_BIT_ALT];
      end
      if (pstrb[0]) begin
        falling_sel_r <= pwdata[`EIVC_POL_MSB:`EIVC_POL_LSB];
      end
    end
  end

  // Status bit follows the CPU, never software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timed_irq_disable_active_r <= 1'b0;
    end else if (ce) begin
      timed_irq_disable_active_r <= timed_irq_disable_in;
    end
  end

  // ****************************************
  // Edge detector
  // ****************************************
  assign eif.ce = ce;
  assign eif.pin = ext_req_pin;
  assign eif.falling_sel = falling_sel_r;

  eivc_edge_det u_det (
    .pclk(pclk),
    .presetn(presetn),
    .eif(eif)
  );

  // ****************************************
  // Flags, mask, interrupt
  // ****************************************
  // Write one clears; a same-cycle edge wins over the clear
  assign stat_nxt = (stat_r & ~(wr_stat ? pwdata[2:0] : 3'h0)) | eif.edge_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= `EIVC_STAT_RST;
      mask_r <= `EIVC_MASK_RST;
    end else if (ce) begin
      stat_r <= stat_nxt;
      if (wr_mask) begin
        mask_r <= pwdata[2:0];
      end
    end
  end

  // Level output, high while any enabled flag stands
  assign irq = |(stat_r & mask_r);

  // ****************************************
  // Vector fetch translation
  // ****************************************
  // Alternate table sits one fixed offset above the standard one
  wire eivc_pkg::eivc_vaddr_t vec_sel = alt_vector_table_sel_r ?
    eivc_pkg::eivc_vaddr_t'(vec_std_addr + `EIVC_ALT_OFS) : vec_std_addr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_addr_r <= 24'h000000;
      vec_ack_r <= 1'b0;
    end else if (ce) begin
      vec_ack_r <= vec_req;
      if (vec_req) begin
        vec_addr_r <= vec_sel;
      end
    end
  end

  assign vec_addr = vec_addr_r;
  assign vec_ack = vec_ack_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Fetch request with the select captured
  sequence s_fetch;
    ce && vec_req;
  endsequence

  property p_alt_sel;
    s_fetch |=> (vec_addr[8] != $past(vec_std_addr[8])) == $past(alt_vector_table_sel_r);
  endproperty
  a_alt_sel: assert property (p_alt_sel) else $error("table select misapplied");

  property p_alt_ofs;
    s_fetch ##0 alt_vector_table_sel_r |=>
      vec_ack && vec_addr == $past(vec_std_addr) + 24'h000100;
  endproperty
  a_alt_ofs: assert property (p_alt_ofs) else $error("alternate vector offset wrong");

  property p_tdis;
    ce |=> ctrl_view[14] == $past(timed_irq_disable_in);
  endproperty
  a_tdis: assert property (p_tdis) else $error("disable status not tracking");

  property p_edge2;
    eif.edge_hit[2] |-> eif.level_prev[2] != eif.level[2] && eif.level[2] == !falling_sel_r[2];
  endproperty
  a_edge2: assert property (p_edge2) else $error("request 2 wrong edge");

  property p_edge1;
    eif.edge_hit[1] |-> eif.level_prev[1] != eif.level[1] && eif.level[1] == !falling_sel_r[1];
  endproperty
  a_edge1: assert property (p_edge1) else $error("request 1 wrong edge");

  property p_edge0;
    eif.edge_hit[0] |-> eif.level_prev[0] != eif.level[0] && eif.level[0] == !falling_sel_r[0];
  endproperty
  a_edge0: assert property (p_edge0) else $error("request 0 wrong edge");

  property p_zero_bits;
    psel && penable && !pwrite && sel == eivc_pkg::EIVC_SEL_CTRL |-> prdata[13:3] == 11'h000;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused control bits nonzero");

  property p_flag_set;
    ce && eif.edge_hit != 3'h0 |=> (stat_r & $past(eif.edge_hit)) == $past(eif.edge_hit);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("edge lost its flag");

  property p_one_shot;
    ce && eif.edge_hit != 3'h0 |=> eif.level_prev == $past(eif.level);
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("edge history not advanced");
endmodule

// *** eivc_consts.svh ***
// Offsets, field positions and reset values of the edge and vector control block
`ifndef EIVC_CONSTS_SVH
`define EIVC_CONSTS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define EIVC_OFF_CTRL 12'h000
`define EIVC_OFF_STAT 12'h004
`define EIVC_OFF_MASK 12'h008
// ****************************************
// Field positions
// ****************************************
`define EIVC_BIT_ALT 15
`define EIVC_BIT_TDIS 14
`define EIVC_POL_MSB 2
`define EIVC_POL_LSB 0
`define EIVC_NSRC 3
// ****************************************
// Reset values
// ****************************************
`define EIVC_ALT_RST 1'h0
`define EIVC_POL_RST 3'h0
`define EIVC_STAT_RST 3'h0
`define EIVC_MASK_RST 3'h0
// ****************************************
// Vector table geometry
// ****************************************
`define EIVC_ALT_OFS 24'h000100
`endif

// *** eivc_pkg.sv ***
// Types shared by the edge and vector control block
package eivc_pkg;
  // ****************************************
  // Types
  // ****************************************
  typedef logic [2:0] eivc_src_t;    // One bit per external request
  typedef logic [15:0] eivc_word_t;  // Register view width
  typedef logic [23:0] eivc_vaddr_t; // Program memory vector address
  // Register selected by a bus address
  typedef enum logic [1:0] {
    EIVC_SEL_CTRL = 2'h0,
    EIVC_SEL_STAT = 2'h1,
    EIVC_SEL_MASK = 2'h3,
    EIVC_SEL_NONE = 2'h2
  } eivc_regsel_e;
endpackage

// *** eivc_edge_if.sv ***
// Signals between the register block and the pin edge detector
`timescale 1ns/10ps
interface eivc_edge_if;
  logic ce;                        // Clock enable, freezes detector
  eivc_pkg::eivc_src_t pin;        // Raw external request pins
  eivc_pkg::eivc_src_t falling_sel; // 1 picks the falling edge
  eivc_pkg::eivc_src_t level;      // Synchronised current level
  eivc_pkg::eivc_src_t level_prev; // Level one enabled cycle earlier
  eivc_pkg::eivc_src_t edge_hit;   // Selected edge seen this cycle
  // Detector side
  modport det (
    input ce, pin, falling_sel,
    output level, level_prev, edge_hit
  );
  // Register block side
  modport ctl (
    output ce, pin, falling_sel,
    input level, level_prev, edge_hit
  );
endinterface

// *** eivc_edge_det.sv ***
// Synchroniser and polarity-selected edge detector for the external requests
`timescale 1ns/10ps
`include "eivc_consts.svh"
module eivc_edge_det (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to the register block
  eivc_edge_if.det eif
);
  // ****************************************
  // Per-pin pipeline
  // ****************************************
  // Flops live per pin so each process owns its own variables
  genvar k;
  generate
    for (k = 0; k < `EIVC_NSRC; k++) begin : g_pin
      logic meta_r; // First stage, read only by the second
      logic cur_r;  // Second stage, safe to compare
      logic prev_r; // Previous safe sample
      // Two-flop synchroniser plus history flop
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r <= 1'b0;
          cur_r <= 1'b0;
          prev_r <= 1'b0;
        end else if (eif.ce) begin
          meta_r <= eif.pin[k];
          cur_r <= meta_r;
          prev_r <= cur_r;
        end
      end
      // Edge exists when samples differ; new level picks its direction
      assign eif.edge_hit[k] = eif.ce & (cur_r ^ prev_r)
                               & (cur_r ^ eif.falling_sel[k]);
      assign eif.level[k] = cur_r;
      assign eif.level_prev[k] = prev_r;
    end
  endgenerate
endmodule

// *** eivc_pin_model.sv ***
// Board logic model that drives the three external request pins
`timescale 1ns/10ps
module eivc_pin_model (
  // Clock
  input wire logic pclk,
  // Pins toward the block
  output logic [2:0] pin
);
  // Pins idle low from time zero
  initial begin
    pin = 3'h0;
  end
  // Toggle one pin just after an edge; the level then holds for many cycles
  task automatic flip(input int i);
    @(posedge pclk);
    pin[i] <= ~pin[i];
  endtask
  // Set all pins at once, used to reach a new starting level
  task automatic set_all(input logic lvl);
    @(posedge pclk);
    pin <= {3{lvl}};
  endtask
endmodule

// *** ext_irq_edge_and_vector_ctrl_bench.sv ***
// Self-checking bench for the edge and vector control block
`timescale 1ns/10ps
`include "eivc_consts.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module ext_irq_edge_and_vector_ctrl_bench;
  // Row: control write, disable input, expected readback and vector
  typedef struct {logic [31:0] wd; logic tdis; logic [31:0] rd; logic [23:0] va;} eivc_row_s;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, e, tdis = 0, vec_req = 0, vec_ack, irq;
  logic [23:0] vec_std_addr = 24'h0, vec_addr;
  logic [2:0] pins;
  int fails = 0, check_count = 0;
  eivc_row_s rows [3] = '{'{32'hffff_ffff, 1'b0, 32'h0000_8007, 24'h000114},
    '{32'h0000_0002, 1'b1, 32'h0000_4002, 24'h000014},
    '{32'h0000_4005, 1'b0, 32'h0000_0005, 24'h000014}};
  // 20 MHz clock
  always #25 pclk = ~pclk;
  eivc_pin_model i_pins (.pclk(pclk), .pin(pins));
  eivc_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_req_pin(pins), .timed_irq_disable_in(tdis),
    .vec_req(vec_req), .vec_std_addr(vec_std_addr), .vec_addr(vec_addr), .vec_ack(vec_ack),
    .irq(irq));
  // Counts and verdict, the single end of the run
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One APB transfer; the wait on pready is bounded so a hang ends the run
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    // Reset values, then an unmapped place
    for (int k = 0; k < 3; k++) begin
      apb(0, 12'(4 * k), 32'h0, q, e);
      `CHK("reset word", 32'h0, q)
    end
    apb(0, 12'h00c, 32'h0, q, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("ready", 1'b1, pready)
    $display("test reset done");
    // Control rows with a vector fetch after each
    foreach (rows[r]) begin
      tdis <= rows[r].tdis;
      apb(1, `EIVC_OFF_CTRL, rows[r].wd, q, e);
      apb(0, `EIVC_OFF_CTRL, 32'h0, q, e);
      `CHK("control", rows[r].rd, q)
      vec_std_addr <= 24'h000014;
      vec_req <= 1;
      @(posedge pclk);
      vec_req <= 0;
      #1;
      `CHK("vec ack", 1'b1, vec_ack)
      `CHK("vec addr", rows[r].va, vec_addr)
      @(posedge pclk);
    end
    $display("test rows done");
    // Each pin, both polarities: wrong edge ignored, right edge flags once
    apb(1, `EIVC_OFF_MASK, 32'h7, q, e);
    for (int p = 1; p >= 0; p--) begin
      if (p == 0) i_pins.set_all(1'b1);
      repeat (6) @(posedge pclk);
      apb(1, `EIVC_OFF_CTRL, {29'h0, {3{p[0]}}}, q, e);
      apb(1, `EIVC_OFF_STAT, 32'h7, q, e);
      for (int i = 0; i < 3; i++) begin
        i_pins.flip(i);
        repeat (6) @(posedge pclk);
        apb(0, `EIVC_OFF_STAT, 32'h0, q, e);
        `CHK("wrong edge", 32'h0, q)
        i_pins.flip(i);
        repeat (6) @(posedge pclk);
        apb(0, `EIVC_OFF_STAT, 32'h0, q, e);
        `CHK("right edge", 32'h1 << i, q)
        `CHK("irq on", 1'b1, irq)
        apb(1, `EIVC_OFF_MASK, 32'h0, q, e);
        `CHK("irq masked", 1'b0, irq)
        apb(1, `EIVC_OFF_MASK, 32'h7, q, e);
        apb(1, `EIVC_OFF_STAT, 32'h1 << i, q, e);
        apb(0, `EIVC_OFF_STAT, 32'h0, q, e);
        `CHK("cleared", 32'h0, q)
        `CHK("irq off", 1'b0, irq)
      end
    end
    $display("test edges done");
    // Mid-run reset with pins high: one rising edge per pin after release
    presetn <= 0;
    repeat (2) @(posedge pclk);
    `CHK("reset irq", 1'b0, irq)
    presetn <= 1;
    repeat (4) @(posedge pclk);
    apb(0, `EIVC_OFF_STAT, 32'h0, q, e);
    `CHK("release flags", 32'h7, q)
    $display("test reset again done");
    close_out();
  end
endmodule
